// ===== design/pcbs_top.sv
// Power control register, core clock divider and battery switchover logic
`timescale 1ns/10ps
module pcbs_top
	import pcbs_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       arst_n_i,
	input  wire logic       supplies_lost_i,
	input  wire logic       main_low_i,
	input  wire logic       dc_low_i,
	input  wire logic       battery_control_pin_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	output logic            core_clk_en_o,
	output logic            meter_off_o,
	output logic            core_off_o,
	output logic            on_battery_o
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic       lost_q;
	logic       main_low_q;
	logic       dc_low_q;
	logic       pin_q;
	logic       pin_prev_r;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_r    <= 3'h4;
			sync2_r    <= 3'h4;
			pin_prev_r <= 1'b1;
		end else begin
			sync1_r    <= {battery_control_pin_i, dc_low_i, main_low_i};
			sync2_r    <= sync1_r;
			pin_prev_r <= sync2_r[2];
		end
	end

	logic [1:0] lost_sync_r;
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lost_sync_r <= 2'h0;
		end else begin
			lost_sync_r <= {lost_sync_r[0], supplies_lost_i};
		end
	end

	assign lost_q     = lost_sync_r[1];
	assign main_low_q = sync2_r[0];
	assign dc_low_q   = sync2_r[1];
	assign pin_q      = sync2_r[2];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] power_control_r;
	logic       key_armed_r;
	logic [1:0] switchover_select_r;
	logic       switch_disable_r;
	logic [2:0] external_pin_one_function_r;
	logic       switchover_flag_r;
	logic       supply_restored_flag_r;
	logic [7:0] scratch_r [SCRATCH_COUNT];
	pcbs_src_e  src_r;

	logic wr_pc;
	logic wr_key;
	logic wr_flags;
	assign wr_pc    = wr_i && (addr_i == ADDR_POWER_CONTROL);
	assign wr_key   = wr_i && (addr_i == ADDR_WRITE_KEY);
	assign wr_flags = wr_i && (addr_i == ADDR_FLAGS);

	function automatic logic is_scratch(input logic [7:0] a);
		return (a >= ADDR_SCRATCH_FIRST) && (a <= ADDR_SCRATCH_LAST);
	endfunction

	// Any write other than the key consumes the unlock
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			key_armed_r <= 1'b0;
		end else if (wr_i) begin
			key_armed_r <= wr_key && (wdata_i == WRITE_KEY_VALUE);
		end
	end

	// Reserved bits 7 and 3 and bit 5 are held at fixed values
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			power_control_r <= POWER_CONTROL_RST;
		end else if (wr_pc && key_armed_r) begin
			power_control_r <= (wdata_i & POWER_CONTROL_WMASK) | (POWER_CONTROL_RST & ~POWER_CONTROL_WMASK);
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			switchover_select_r         <= SEL_MAIN_ONLY;
			switch_disable_r            <= 1'b0;
			external_pin_one_function_r <= 3'h0;
		end else if (wr_i) begin
			if (addr_i == ADDR_SWITCH_CONFIG) begin
				switchover_select_r <= wdata_i[1:0];
				switch_disable_r    <= wdata_i[BIT_SWITCH_DISABLE];
			end
			if (addr_i == ADDR_PIN_CONFIG) begin
				external_pin_one_function_r <= wdata_i[PIN_FUNC_LSB +: 3];
			end
		end
	end

	// Scratch pads survive mode changes; only total supply loss or the asynchronous reset clears them
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < SCRATCH_COUNT; i++) begin
				scratch_r[i] <= 8'h00;
			end
		end else if (lost_q) begin
			for (int i = 0; i < SCRATCH_COUNT; i++) begin
				scratch_r[i] <= 8'h00;
			end
		end else if (wr_i && is_scratch(addr_i)) begin
			scratch_r[2'(addr_i - ADDR_SCRATCH_FIRST)] <= wdata_i;
		end
	end

	// ------------------------------------------------------------
	// Switchover decision
	// ------------------------------------------------------------
	logic auto_en;
	logic pin_en;
	logic go_battery;
	logic go_main;
	// Switch bit 1 is also select bit 1, so either view disables switching
	assign auto_en = !switch_disable_r && !switchover_select_r[1];
	assign pin_en  = auto_en && (external_pin_one_function_r[1:0] == PIN_FUNC_BATTERY);
	assign go_battery = auto_en && (main_low_q
		|| ((switchover_select_r == SEL_MAIN_AND_DC) && dc_low_q)
		|| (pin_en && pin_prev_r && !pin_q));
	assign go_main = !main_low_q
		&& !((switchover_select_r == SEL_MAIN_AND_DC) && dc_low_q)
		&& !(pin_en && !pin_q);

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			src_r <= PCBS_MAIN;
		end else begin
			case (src_r)
				PCBS_MAIN: begin
					if (go_battery) begin
						src_r <= PCBS_BATT;
					end
				end
				PCBS_BATT: begin
					if (go_main || !auto_en) begin
						src_r <= PCBS_MAIN;
					end
				end
				default: begin
					src_r <= PCBS_MAIN;
				end
			endcase
		end
	end

	logic to_batt;
	logic to_main;
	assign to_batt = (src_r == PCBS_MAIN) && go_battery;
	assign to_main = (src_r == PCBS_BATT) && (go_main || !auto_en);

	// Set wins over a clearing write in the same cycle
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			switchover_flag_r      <= 1'b0;
			supply_restored_flag_r <= 1'b0;
		end else begin
			if (to_batt) begin
				switchover_flag_r <= 1'b1;
			end else if (wr_flags && !wdata_i[BIT_SWITCHOVER_FLAG]) begin
				switchover_flag_r <= 1'b0;
			end
			if (to_main) begin
				supply_restored_flag_r <= 1'b1;
			end else if (wr_flags && !wdata_i[BIT_RESTORED_FLAG]) begin
				supply_restored_flag_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic [10:0] base_cnt_r;
	logic [6:0]  div_cnt_r;
	logic        base_tick;
	assign base_tick = (base_cnt_r == 11'(BASE_DIV - 1));

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			base_cnt_r <= 11'h000;
			div_cnt_r  <= 7'h00;
		end else if (base_tick) begin
			base_cnt_r <= 11'h000;
			div_cnt_r  <= div_cnt_r + 7'h01;
		end else begin
			base_cnt_r <= base_cnt_r + 11'h001;
		end
	end

	// Core enable pulses at 4.096 MHz / 2^divider; low bits of counter all ones
	logic [6:0] div_mask;
	assign div_mask = 7'((8'h01 << power_control_r[DIV_MSB:0]) - 8'h01);

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			core_clk_en_o <= 1'b0;
			meter_off_o   <= 1'b0;
			core_off_o    <= 1'b0;
			on_battery_o  <= 1'b0;
		end else begin
			// Metering is cut on battery; the core also stops there if the core shutdown bit is set
			core_clk_en_o <= base_tick && ((div_cnt_r & div_mask) == div_mask) && !core_off_o;
			meter_off_o   <= power_control_r[BIT_METER_OFF] || (src_r == PCBS_BATT);
			core_off_o    <= power_control_r[BIT_CORE_SHUTDOWN] && (src_r == PCBS_BATT);
			on_battery_o  <= (src_r == PCBS_BATT);
		end
	end

	// Source flag sits alone in its byte; the other peripheral bits read zero
	logic [7:0] peripheral_config_register_rd;
	always_comb begin
		peripheral_config_register_rd                  = 8'h00;
		peripheral_config_register_rd[BIT_SOURCE_FLAG] = (src_r == PCBS_MAIN);
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			if (addr_i == ADDR_POWER_CONTROL) begin
				rdata_o <= power_control_r;
			end else if (addr_i == ADDR_PERIPHERAL_CONFIG_REGISTER_CONFIG) begin
				rdata_o <= peripheral_config_register_rd;
			end else if (addr_i == ADDR_SWITCH_CONFIG) begin
				rdata_o <= {6'h00, switchover_select_r[1] | switch_disable_r, switchover_select_r[0]};
			end else if (addr_i == ADDR_PIN_CONFIG) begin
				rdata_o <= {4'h0, external_pin_one_function_r, 1'b0};
			end else if (addr_i == ADDR_FLAGS) begin
				rdata_o <= {supply_restored_flag_r, 5'h00, switchover_flag_r, 1'b0};
			end else if (is_scratch(addr_i)) begin
				rdata_o <= scratch_r[2'(addr_i - ADDR_SCRATCH_FIRST)];
			end else begin
				rdata_o <= 8'h00;
			end
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence key_then_pc_s;
		wr_key && (wdata_i == WRITE_KEY_VALUE) ##1 wr_pc;
	endsequence

	unkeyed_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_pc && !key_armed_r) |=> $stable(power_control_r))
		else $error("power control changed without key");
	keyed_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		key_then_pc_s |=> power_control_r[DIV_MSB:0] == $past(wdata_i[DIV_MSB:0]))
		else $error("keyed power control write lost");
	reserved_bits_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		power_control_r[7] && !power_control_r[5] && !power_control_r[3])
		else $error("reserved power control bits wrong");
	meter_off_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		power_control_r[BIT_METER_OFF] |=> meter_off_o)
		else $error("metering not powered down");
	core_off_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(power_control_r[BIT_CORE_SHUTDOWN] && src_r == PCBS_BATT) |=> core_off_o)
		else $error("core not shut down in battery mode");
	main_low_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(auto_en && main_low_q && src_r == PCBS_MAIN) |=> src_r == PCBS_BATT)
		else $error("no switch on low main supply");
	disabled_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(!auto_en && src_r == PCBS_MAIN) |=> src_r == PCBS_MAIN)
		else $error("switched while disabled");
	flag_set_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		to_batt |=> switchover_flag_r)
		else $error("switchover flag not set");
	scratch_keep_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(!lost_q && !wr_i) |=> scratch_r[0] == $past(scratch_r[0]))
		else $error("scratch pad changed");

	sequence pin_fall_s;
		pin_q ##1 (pin_en && !pin_q && src_r == PCBS_MAIN);
	endsequence

	dc_low_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(auto_en && switchover_select_r == SEL_MAIN_AND_DC && dc_low_q && src_r == PCBS_MAIN) |=> src_r == PCBS_BATT)
		else $error("no switch on low DC input");
	pin_edge_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		pin_fall_s |=> src_r == PCBS_BATT)
		else $error("no switch on battery control pin edge");
	return_main_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(src_r == PCBS_BATT && auto_en && !main_low_q && switchover_select_r == SEL_MAIN_ONLY && !pin_en)
		|=> src_r == PCBS_MAIN)
		else $error("no return to main supply");
	restored_flag_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		to_main |=> supply_restored_flag_r)
		else $error("restored flag not set");
	flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_flags && !wdata_i[BIT_SWITCHOVER_FLAG] && !to_batt) |=> !switchover_flag_r)
		else $error("switchover flag not cleared");
	battery_meter_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(src_r == PCBS_BATT) |=> (meter_off_o && on_battery_o))
		else $error("metering or source output wrong on battery");
	core_stop_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		core_off_o |=> !core_clk_en_o)
		else $error("core clock running while shut down");
	scratch_wipe_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		lost_q |=> scratch_r[SCRATCH_COUNT-1] == 8'h00)
		else $error("scratch pad kept after supply loss");

endmodule // pcbs_top

// ===== common/pcbs_pkg.sv
// Package: register map, field positions, reset values and timing for power control and switchover
package pcbs_pkg;

	// ------------------------------------------------------------
	// Register addresses (8-bit register space)
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_POWER_CONTROL  = 8'hc5;
	localparam logic [7:0] ADDR_WRITE_KEY      = 8'hc1;
	localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_REGISTER_CONFIG  = 8'hf4;
	localparam logic [7:0] ADDR_SWITCH_CONFIG  = 8'hf5;
	localparam logic [7:0] ADDR_FLAGS          = 8'hf8;
	localparam logic [7:0] ADDR_PIN_CONFIG     = 8'hff;
	localparam logic [7:0] ADDR_SCRATCH_FIRST  = 8'hfb;
	localparam logic [7:0] ADDR_SCRATCH_LAST   = 8'hfe;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] WRITE_KEY_VALUE     = 8'ha7;
	localparam logic [7:0] POWER_CONTROL_RST   = 8'h82;
	localparam logic [7:0] POWER_CONTROL_WMASK = 8'h57;
	localparam int         BIT_METER_OFF       = 6;
	localparam int         BIT_CORE_SHUTDOWN   = 4;
	localparam int         DIV_MSB             = 2;
	localparam int         BIT_SWITCH_DISABLE  = 1;
	localparam int         BIT_SOURCE_FLAG     = 6;
	localparam int         BIT_SWITCHOVER_FLAG = 1;
	localparam int         BIT_RESTORED_FLAG   = 7;
	localparam int         PIN_FUNC_LSB        = 1;
	localparam logic [1:0] PIN_FUNC_BATTERY    = 2'h1;
	localparam logic [1:0] SEL_MAIN_ONLY       = 2'h0;
	localparam logic [1:0] SEL_MAIN_AND_DC     = 2'h1;
	localparam int         SCRATCH_COUNT       = 4;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int SYS_CLK_MHZ   = 200;
	localparam int BASE_CLK_KHZ  = 4096;
	// Base clock is approximated by rounding 200 MHz / 4.096 MHz down
	localparam int BASE_DIV      = (SYS_CLK_MHZ * 1000) / BASE_CLK_KHZ;

	typedef enum logic [1:0] {
		PCBS_MAIN = 2'b01,
		PCBS_BATT = 2'b10
	} pcbs_src_e;

endpackage

// ===== dv/pcbs_supply_model.sv
// Model of the external supply supervisor: main and DC monitors, battery control pin
`timescale 1ns/10ps
module pcbs_supply_model #(
	parameter int LAG = 3
) (
	input  wire logic clk_sys_i,
	input  wire logic main_fail_i,
	input  wire logic dc_fail_i,
	input  wire logic pin_drop_i,
	input  wire logic wipe_i,
	output logic      main_low_o,
	output logic      dc_low_o,
	output logic      pin_o,
	output logic      lost_o
);
	// -------------------------------------------------
	// Comparator lag
	// -------------------------------------------------
	// No reset: the supervisor runs from power-up, ahead of the device
	logic [3:0] stage_r [LAG] = '{default: 4'h0};

	always @(posedge clk_sys_i) begin
		stage_r[0] <= {wipe_i, pin_drop_i, dc_fail_i, main_fail_i};
		for (int i = 1; i < LAG; i++) begin
			stage_r[i] <= stage_r[i-1];
		end
	end

	assign main_low_o = stage_r[LAG-1][0];
	assign dc_low_o   = stage_r[LAG-1][1];
	// Pin idles high through its pull-up; a drop is a falling edge
	assign pin_o      = ~stage_r[LAG-1][2];
	assign lost_o     = stage_r[LAG-1][3];
endmodule // pcbs_supply_model

// ===== dv/tb_power_control_battery_switchover.sv
// Self-checking testbench for the power control and battery switchover block
`timescale 1ns/10ps
module tb_power_control_battery_switchover import pcbs_pkg::*;;
	logic       clk_sys_i = 1'b0;
	logic       arst_n_i  = 1'b0;
	logic [7:0] addr_i    = 8'h00;
	logic [7:0] wdata_i   = 8'h00;
	logic       wr_i      = 1'b0;
	logic       rd_i      = 1'b0;
	logic       main_fail = 1'b0;
	logic       dc_fail   = 1'b0;
	logic       pin_drop  = 1'b0;
	logic       wipe      = 1'b0;
	logic       main_low, dc_low, pin_lvl, lost;
	logic [7:0] rdata_o, d;
	logic       core_clk_en_o, meter_off_o, core_off_o, on_battery_o;
	int         fail_count = 0;
	int         samples_checked = 0;
	int         pulses = 0;

	always #2.5 clk_sys_i = ~clk_sys_i;

	pcbs_supply_model #(.LAG(3)) i_sup (.clk_sys_i(clk_sys_i), .main_fail_i(main_fail), .dc_fail_i(dc_fail),
		.pin_drop_i(pin_drop), .wipe_i(wipe), .main_low_o(main_low), .dc_low_o(dc_low), .pin_o(pin_lvl),
		.lost_o(lost));

	pcbs_top i_dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .supplies_lost_i(lost), .main_low_i(main_low),
		.dc_low_i(dc_low), .battery_control_pin_i(pin_lvl), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .core_clk_en_o(core_clk_en_o), .meter_off_o(meter_off_o),
		.core_off_o(core_off_o), .on_battery_o(on_battery_o));

	// -------------------------------------------------
	// Bus and check tasks
	// -------------------------------------------------
	task automatic complete_run();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i  <= a;
		wdata_i <= v;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask

	// Key and power control write back to back, strobe held high across both
	task automatic pc_wr(input logic [7:0] v);
		@(posedge clk_sys_i);
		addr_i  <= ADDR_WRITE_KEY;
		wdata_i <= WRITE_KEY_VALUE;
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		addr_i  <= ADDR_POWER_CONTROL;
		wdata_i <= v;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask

	task automatic wait_batt(input logic exp);
		int n;
		n = 0;
		while (on_battery_o !== exp && n < 40) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk("on_battery", {15'h0, exp}, {15'h0, on_battery_o});
		if (on_battery_o !== exp) complete_run();
	endtask

	// Interval between the second and third enable pulses, clear of the divider change
	task automatic period(input logic [2:0] cd);
		int n, k, t;
		k = 0;
		t = 0;
		pc_wr({5'h0, cd});
		for (n = 0; n < 20000 && k < 3; n++) begin
			@(posedge clk_sys_i);
			if (core_clk_en_o === 1'b1) begin
				k++;
				if (k == 2) t = n;
				if (k == 3) t = n - t;
			end
		end
		chk("core_pulses", 16'h3, 16'(k));
		chk("core_period", 16'(BASE_DIV << cd), 16'(t));
		if (k < 3) complete_run();
	endtask

	// -------------------------------------------------
	// Main sequence
	// -------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rd(ADDR_POWER_CONTROL, d);
		chk("pc_reset", 8'h82, d);
		rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CONFIG, d);
		chk("src_main", 8'h40, d & 8'h40);
		rd(ADDR_SWITCH_CONFIG, d);
		chk("sel_reset", 8'h00, d & 8'h03);
		rd(8'h00, d);
		chk("unmapped", 8'h00, d);
		wr(ADDR_POWER_CONTROL, 8'h40);
		wr(ADDR_WRITE_KEY, WRITE_KEY_VALUE);
		wr(ADDR_SCRATCH_FIRST, 8'h11);
		wr(ADDR_POWER_CONTROL, 8'h40);
		rd(ADDR_POWER_CONTROL, d);
		chk("pc_locked", 8'h82, d);
		pc_wr(8'h5f);
		rd(ADDR_POWER_CONTROL, d);
		chk("pc_mask", 8'hd7, d);
		chk("meter_off", 16'h1, meter_off_o);
		chk("core_on_main", 16'h0, core_off_o);
		for (int i = 0; i < 8; i++) period(3'(i));
		pc_wr(8'h12);
		for (int i = 0; i < SCRATCH_COUNT; i++) wr(ADDR_SCRATCH_FIRST + 8'(i), 8'h3c + 8'(i));
		main_fail <= 1'b1;
		wait_batt(1'b1);
		chk("meter_batt", 16'h1, meter_off_o);
		chk("sleep", 16'h1, core_off_o);
		// Two full core periods at divider 2: no enable pulse may appear in sleep
		pulses = 0;
		repeat (400) begin
			@(posedge clk_sys_i);
			if (core_clk_en_o !== 1'b0) pulses++;
		end
		chk("core_stopped", 16'h0, 16'(pulses));
		rd(ADDR_PERIPHERAL_CONFIG_REGISTER_CONFIG, d);
		chk("src_batt", 8'h00, d & 8'h40);
		main_fail <= 1'b0;
		wait_batt(1'b0);
		rd(ADDR_FLAGS, d);
		chk("flags_set", 8'h82, d & 8'h82);
		wr(ADDR_FLAGS, 8'h00);
		rd(ADDR_FLAGS, d);
		chk("flags_clr", 8'h00, d & 8'h82);
		for (int i = 0; i < SCRATCH_COUNT; i++) begin
			rd(ADDR_SCRATCH_FIRST + 8'(i), d);
			chk("scratch_kept", 8'h3c + 8'(i), d);
		end
		wr(ADDR_SWITCH_CONFIG, 8'h01);
		dc_fail <= 1'b1;
		wait_batt(1'b1);
		dc_fail <= 1'b0;
		wait_batt(1'b0);
		for (int s = 0; s < 3; s++) begin
			wr(ADDR_SWITCH_CONFIG, (s == 0) ? 8'h00 : 8'(s + 1));
			dc_fail   <= (s == 0);
			main_fail <= (s != 0);
			repeat (12) @(posedge clk_sys_i);
			chk("no_switch", 16'h0, on_battery_o);
			dc_fail   <= 1'b0;
			main_fail <= 1'b0;
		end
		// Let the supervisor lag drain before switching is enabled again
		repeat (8) @(posedge clk_sys_i);
		wr(ADDR_SWITCH_CONFIG, 8'h00);
		wr(ADDR_PIN_CONFIG, 8'h02);
		pin_drop <= 1'b1;
		wait_batt(1'b1);
		pin_drop <= 1'b0;
		wait_batt(1'b0);
		wipe <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		wipe <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		rd(ADDR_SCRATCH_LAST, d);
		chk("scratch_lost", 8'h00, d);
		complete_run();
	end
endmodule // tb_power_control_battery_switchover
